// [hdl/supply_select_reset_supervisor.sv]
// Supply source selection, power-on qualification, output switch control
// and system reset indicator. Comparator and pin inputs are assumed
// synchronous to mclk; analog thresholds live outside this block.
`timescale 1ns/1ps
module supply_select_reset_supervisor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic main_supply_good,
   input wire logic bus_supply_good,
   input wire logic aux_output_uv,
   input wire logic manual_reset_input,
   input wire logic mr_active_low_cfg,
   input wire supply_pkg::sw_cond_t switch_cond_cfg,
   input wire logic [1:0] uv_threshold_cfg,
   output logic power_from_main,
   output logic power_from_bus,
   output logic dead_battery,
   output logic core_hard_reset,
   output logic main_domain_en,
   output logic bus_domain_en,
   output logic switched_aux_output_en,
   output logic [1:0] uv_threshold_sel,
   output logic system_reset_indicator_n
);
   import supply_pkg::*;

   logic [NUM_SUP-1:0] sup_good;
   logic [NUM_SUP-1:0] qual_reg;
   logic [NUM_SUP-1:0] qual_next;
   src_state_t state_reg;
   src_state_t state_next;
   logic [CNT_W-1:0] hr_cnt_reg;
   logic [CNT_W-1:0] hr_cnt_next;
   logic main_reg, main_next;
   logic bus_reg, bus_next;
   logic dead_reg, dead_next;
   logic hard_reg, hard_next;
   logic sw_en_reg, sw_en_next;
   logic [1:0] thr_reg, thr_next;
   logic rst_n_reg, rst_n_next;
   logic mr_asserted;

   assign sup_good = {bus_supply_good, main_supply_good};

   // One power-on qualifier per supply; drop is immediate, rise waits
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SUP; gi++) begin : g_por
         logic [CNT_W-1:0] cnt_reg;
         logic [CNT_W-1:0] cnt_next;
         always_comb begin
            cnt_next = cnt_reg;
            qual_next[gi] = 1'b0;
            if (!sup_good[gi]) begin
               cnt_next = CNT_ZERO;
            end else if (cnt_reg == POR_QUAL_MAX) begin
               qual_next[gi] = 1'b1;
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               cnt_reg <= CNT_ZERO;
               qual_reg[gi] <= 1'b0;
            end else begin
               cnt_reg <= cnt_next;
               qual_reg[gi] <= qual_next[gi];
            end
         end
      end
   endgenerate

   // Source selection; going bus to main is seamless, main to bus is not
   always_comb begin
      state_next = state_reg;
      hr_cnt_next = CNT_ZERO;
      unique case (state_reg)
         ST_OFF: begin
            if (qual_reg[SUP_MAIN]) begin
               state_next = ST_MAIN;
            end else if (qual_reg[SUP_BUS]) begin
               state_next = ST_BUS;
            end
         end
         ST_BUS: begin
            if (qual_reg[SUP_MAIN]) begin
               state_next = ST_MAIN;
            end else if (!qual_reg[SUP_BUS]) begin
               state_next = ST_OFF;
            end
         end
         ST_MAIN: begin
            if (!qual_reg[SUP_MAIN]) begin
               // Bus still up: the core cannot ride through, so reboot
               state_next = qual_reg[SUP_BUS] ? ST_HARD_RESET : ST_OFF;
            end
         end
         ST_HARD_RESET: begin
            hr_cnt_next = hr_cnt_reg + 8'h01;
            if (hr_cnt_reg == HARD_RESET_MAX) begin
               hr_cnt_next = CNT_ZERO;
               if (qual_reg[SUP_MAIN]) begin
                  state_next = ST_MAIN;
               end else if (qual_reg[SUP_BUS]) begin
                  state_next = ST_BUS;
               end else begin
                  state_next = ST_OFF;
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_OFF;
         hr_cnt_reg <= CNT_ZERO;
      end else begin
         state_reg <= state_next;
         hr_cnt_reg <= hr_cnt_next;
      end
   end

   // Polarity is applied live from mr_active_low_cfg; this block gives it no reset value
   assign mr_asserted = manual_reset_input ^ mr_active_low_cfg;

   // Output flags, switch enable and reset indicator
   always_comb begin
      main_next = (state_next == ST_MAIN);
      bus_next = (state_next == ST_BUS);
      hard_next = (state_next == ST_HARD_RESET);
      dead_next = !qual_reg[SUP_MAIN];
      thr_next = uv_threshold_cfg;
      rst_n_next = !(aux_output_uv || mr_asserted);
      // The switch only joins the main input, so never without it
      sw_en_next = 1'b0;
      if (qual_reg[SUP_MAIN]) begin
         unique case (switch_cond_cfg)
            SW_NEVER: sw_en_next = 1'b0;
            SW_MAIN_GOOD: sw_en_next = 1'b1;
            SW_ON_MAIN: sw_en_next = (state_reg == ST_MAIN);
            SW_OUT_OF_RESET: sw_en_next = (state_reg == ST_MAIN) &&
               !mr_asserted;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         main_reg <= 1'b0;
         bus_reg <= 1'b0;
         hard_reg <= 1'b0;
         dead_reg <= 1'b1;
         thr_reg <= UV_THR_RESET;
         rst_n_reg <= 1'b0;
         sw_en_reg <= 1'b0;
      end else begin
         main_reg <= main_next;
         bus_reg <= bus_next;
         hard_reg <= hard_next;
         dead_reg <= dead_next;
         thr_reg <= thr_next;
         rst_n_reg <= rst_n_next;
         sw_en_reg <= sw_en_next;
      end
   end

   assign power_from_main = main_reg;
   assign power_from_bus = bus_reg;
   assign dead_battery = dead_reg;
   assign core_hard_reset = hard_reg;
   assign main_domain_en = qual_reg[SUP_MAIN];
   assign bus_domain_en = qual_reg[SUP_BUS];
   assign switched_aux_output_en = sw_en_reg;
   assign uv_threshold_sel = thr_reg;
   assign system_reset_indicator_n = rst_n_reg;

   // Consecutive good main samples, saturating; feeds the qualifier checks
   logic [CNT_W-1:0] good_run_reg;
   logic [CNT_W-1:0] good_run_next;
   always_comb begin
      good_run_next = CNT_ZERO;
      if (main_supply_good) begin
         good_run_next = good_run_reg;
         if (good_run_reg != 8'hFF) begin
            good_run_next = good_run_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         good_run_reg <= CNT_ZERO;
      end else begin
         good_run_reg <= good_run_next;
      end
   end

   prefer_main_a: assert property (
      @(posedge mclk) disable iff (rst)
      qual_reg[SUP_MAIN] && bus_domain_en && state_reg == ST_OFF
      |=> power_from_main ##1 power_from_main || !main_domain_en)
      else $error("main input not preferred");

   bus_select_a: assert property (
      @(posedge mclk) disable iff (rst)
      !main_domain_en && bus_domain_en && state_reg == ST_OFF
      |=> power_from_bus && !power_from_main)
      else $error("bus supply not selected");

   seamless_switch_a: assert property (
      @(posedge mclk) disable iff (rst)
      state_reg == ST_BUS && main_domain_en
      |=> power_from_main && !core_hard_reset)
      else $error("switch to main caused reset");

   hard_reset_a: assert property (
      @(posedge mclk) disable iff (rst)
      state_reg == ST_MAIN && !main_domain_en && bus_domain_en
      |=> core_hard_reset [*8])
      else $error("no hard reset on main loss");

   dead_battery_a: assert property (
      @(posedge mclk) disable iff (rst)
      !main_supply_good |=> ##1 dead_battery)
      else $error("dead battery not flagged");

   por_hold_a: assert property (
      @(posedge mclk) disable iff (rst)
      $rose(main_domain_en) |-> good_run_reg > POR_QUAL_MAX)
      else $error("domain released before qualified");

   por_release_a: assert property (
      @(posedge mclk) disable iff (rst)
      main_supply_good && good_run_reg == POR_QUAL_MAX |=> main_domain_en)
      else $error("domain not released when qualified");

   threshold_a: assert property (
      @(posedge mclk) disable iff (rst)
      $changed(uv_threshold_cfg) |=> uv_threshold_sel ==
      $past(uv_threshold_cfg))
      else $error("threshold not applied");

   switch_gate_a: assert property (
      @(posedge mclk) disable iff (rst)
      switched_aux_output_en |-> $past(main_domain_en) &&
      $past(switch_cond_cfg) != SW_NEVER)
      else $error("switch enabled without condition");

   uv_reset_a: assert property (
      @(posedge mclk) disable iff (rst)
      aux_output_uv |=> !system_reset_indicator_n)
      else $error("undervoltage did not assert reset");

   manual_reset_a: assert property (
      @(posedge mclk) disable iff (rst)
      manual_reset_input != mr_active_low_cfg
      |=> !system_reset_indicator_n)
      else $error("manual reset not honoured");

   release_a: assert property (
      @(posedge mclk) disable iff (rst)
      !aux_output_uv && manual_reset_input == mr_active_low_cfg
      |=> system_reset_indicator_n)
      else $error("reset indicator not released");
endmodule // supply_select_reset_supervisor

// [hdl/supply_pkg.sv]
// Constants and types for the supply select and reset supervisor.
// Assumes a single 40 MHz core clock and comparator levels on mclk.
package supply_pkg;
   // Core clock period
   localparam int MCLK_PERIOD_NS = 25;
   // Supply must hold good this long before its domain is released
   localparam int POR_QUAL_NS = 2000;
   localparam int POR_QUAL_CYC =
      (POR_QUAL_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   // Length of the core hard reset pulse on loss of the main input
   localparam int HARD_RESET_NS = 5000;
   localparam int HARD_RESET_CYC =
      (HARD_RESET_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] POR_QUAL_MAX = CNT_W'(POR_QUAL_CYC - 1);
   localparam logic [CNT_W-1:0] HARD_RESET_MAX = CNT_W'(HARD_RESET_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   // Supply indices into the qualifier vector
   localparam int SUP_MAIN = 0;
   localparam int SUP_BUS = 1;
   localparam int NUM_SUP = 2;
   // Switch enable conditions
   typedef enum logic [1:0] {
      SW_NEVER = 2'h0,
      SW_MAIN_GOOD = 2'h1,
      SW_ON_MAIN = 2'h2,
      SW_OUT_OF_RESET = 2'h3
   } sw_cond_t;
   // Power source states, Gray along off, bus, main, hard reset
   typedef enum logic [1:0] {
      ST_OFF = 2'h0,
      ST_BUS = 2'h1,
      ST_MAIN = 2'h3,
      ST_HARD_RESET = 2'h2
   } src_state_t;
   localparam logic [1:0] UV_THR_RESET = 2'h0;
endpackage

// [verif/supply_rails_model.sv]
// Model of the system rails and the board's manual reset button.
// Assumes the bench commands rail states and button presses off-edge.
`timescale 1ns/1ps
module supply_rails_model (
   input wire logic main_on,
   input wire logic bus_on,
   input wire logic uv_force,
   input wire logic mr_press,
   input wire logic mr_active_low_cfg,
   input wire logic switched_aux_output_en,
   output logic main_supply_good,
   output logic bus_supply_good,
   output logic aux_output_uv,
   output logic manual_reset_input
);
   // Rail comparators follow the commanded rail state
   assign main_supply_good = main_on;
   assign bus_supply_good = bus_on;
   // Open switch lets the pulldown drag the output into undervoltage
   assign aux_output_uv = uv_force | ~switched_aux_output_en;
   // Button driver matches the selected polarity
   assign manual_reset_input = mr_press ^ mr_active_low_cfg;
endmodule // supply_rails_model

// [verif/tb_supply_select_reset_supervisor.sv]
// Self-checking bench for the supply select and reset supervisor.
// Assumes the rails model in the same folder and the supply package.
`timescale 1ns/1ps
module tb_supply_select_reset_supervisor;
   import supply_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic main_on = 1'b0;
   logic bus_on = 1'b0;
   logic uv_force = 1'b0;
   logic mr_press = 1'b0;
   logic mr_active_low_cfg = 1'b0;
   sw_cond_t switch_cond_cfg = SW_MAIN_GOOD;
   logic [1:0] uv_threshold_cfg = 2'h0;
   logic main_supply_good, bus_supply_good, aux_output_uv;
   logic manual_reset_input, power_from_main, power_from_bus;
   logic dead_battery, core_hard_reset, main_domain_en, bus_domain_en;
   logic switched_aux_output_en, system_reset_indicator_n;
   logic [1:0] uv_threshold_sel;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;

   always #12.5 mclk = ~mclk;

   supply_select_reset_supervisor u_dut (.mclk(mclk), .rst(rst),
      .main_supply_good(main_supply_good), .bus_supply_good(bus_supply_good),
      .aux_output_uv(aux_output_uv), .manual_reset_input(manual_reset_input),
      .mr_active_low_cfg(mr_active_low_cfg),
      .switch_cond_cfg(switch_cond_cfg), .uv_threshold_cfg(uv_threshold_cfg),
      .power_from_main(power_from_main), .power_from_bus(power_from_bus),
      .dead_battery(dead_battery), .core_hard_reset(core_hard_reset),
      .main_domain_en(main_domain_en), .bus_domain_en(bus_domain_en),
      .switched_aux_output_en(switched_aux_output_en),
      .uv_threshold_sel(uv_threshold_sel),
      .system_reset_indicator_n(system_reset_indicator_n));

   supply_rails_model u_rails (.main_on(main_on), .bus_on(bus_on),
      .uv_force(uv_force), .mr_press(mr_press),
      .mr_active_low_cfg(mr_active_low_cfg),
      .switched_aux_output_en(switched_aux_output_en),
      .main_supply_good(main_supply_good), .bus_supply_good(bus_supply_good),
      .aux_output_uv(aux_output_uv), .manual_reset_input(manual_reset_input));

   task automatic complete_run;
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic got, input logic exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Reset values, then no supply present after release
   task automatic t_reset;
      wait_cyc(20);
      chk(dead_battery, 1'b1, "dead flag in reset");
      chk(system_reset_indicator_n, 1'b0, "indicator in reset");
      rst = 1'b0;
      wait_cyc(3);
      chk(power_from_bus | power_from_main, 1'b0, "source without rail");
   endtask

   // Short main glitch refused, then bus alone qualifies
   task automatic t_bus_start;
      main_on = 1'b1;
      wait_cyc(40);
      main_on = 1'b0;
      wait_cyc(50);
      chk(main_domain_en | power_from_main, 1'b0, "short pulse taken");
      bus_on = 1'b1;
      wait_cyc(79);
      chk(bus_domain_en, 1'b0, "bus released early");
      wait_cyc(4);
      chk(bus_domain_en, 1'b1, "bus not released");
      chk(power_from_bus, 1'b1, "not on bus");
      chk(dead_battery, 1'b1, "dead flag on bus");
   endtask

   // Main arrives while on bus: switch over with no reset pulse
   task automatic t_switch_over;
      int hits;
      hits = 0;
      main_on = 1'b1;
      for (int i = 0; i < 90; i++) begin
         @(negedge mclk);
         if (core_hard_reset !== 1'b0) hits++;
      end
      chk(hits == 0, 1'b1, "reset during switch-over");
      chk(power_from_main & ~power_from_bus, 1'b1, "main not chosen");
      chk(dead_battery, 1'b0, "dead flag with main");
   endtask

   // Every switch condition, with and without manual reset; thresholds
   task automatic t_switch_cond;
      logic exp;
      for (int c = 0; c < 4; c++) begin
         for (int m = 0; m < 2; m++) begin
            switch_cond_cfg = sw_cond_t'(c);
            uv_threshold_cfg = 2'(c);
            mr_press = m[0];
            wait_cyc(3);
            exp = (c != 0) && !(c == 3 && m == 1);
            chk(switched_aux_output_en, exp, "switch enable");
            chk(uv_threshold_sel === 2'(c), 1'b1, "threshold code");
         end
      end
   endtask

   // Indicator over both polarities and both causes together
   task automatic t_indicator;
      switch_cond_cfg = SW_MAIN_GOOD;
      for (int k = 0; k < 8; k++) begin
         mr_active_low_cfg = k[2];
         uv_force = k[1];
         mr_press = k[0];
         wait_cyc(3);
         chk(system_reset_indicator_n, !(k[1] | k[0]), "indicator");
      end
      mr_active_low_cfg = 1'b0;
      uv_force = 1'b0;
      mr_press = 1'b0;
   endtask

   // Main lost with bus present: counted hard reset, then bus, then back
   task automatic t_main_loss;
      int n;
      n = 0;
      main_on = 1'b0;
      for (int i = 0; i < 10 && core_hard_reset !== 1'b1; i++) begin
         @(negedge mclk);
      end
      chk(switched_aux_output_en, 1'b0, "switch without main");
      while (core_hard_reset === 1'b1 && n < 300) begin
         n++;
         @(negedge mclk);
      end
      chk(n == HARD_RESET_CYC, 1'b1, "hard reset length");
      wait_cyc(2);
      chk(power_from_bus & dead_battery, 1'b1, "bus after reset");
      main_on = 1'b1;
      wait_cyc(85);
      chk(power_from_main, 1'b1, "main after return");
   endtask

   // Mid-run reset with both rails up: main taken straight from off
   task automatic t_both_start;
      int hits;
      int n;
      hits = 0;
      n = 0;
      switch_cond_cfg = SW_ON_MAIN;
      rst = 1'b1;
      wait_cyc(4);
      chk(power_from_main | main_domain_en, 1'b0, "state kept in reset");
      rst = 1'b0;
      while (power_from_main !== 1'b1 && n < 100) begin
         n++;
         if (power_from_bus !== 1'b0 || core_hard_reset !== 1'b0) hits++;
         @(negedge mclk);
      end
      chk(hits == 0, 1'b1, "bus chosen over main");
      chk(n == POR_QUAL_CYC + 1, 1'b1, "main qualify time");
      chk(switched_aux_output_en, 1'b0, "switch before on main");
      wait_cyc(1);
      chk(switched_aux_output_en, 1'b1, "switch once on main");
      wait_cyc(2);
      chk(system_reset_indicator_n, 1'b1, "indicator with output up");
      switch_cond_cfg = SW_MAIN_GOOD;
   endtask

   // Hang guard well above the expected run of under 1000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      t_reset();
      t_bus_start();
      t_switch_over();
      t_switch_cond();
      t_indicator();
      t_main_loss();
      t_both_start();
      complete_run();
   end
endmodule // tb_supply_select_reset_supervisor
